// >>> bench/epv_core_model.sv
// ****************************************
// Core: one-cycle acknowledge, vector fetch
// ****************************************
module epv_core_model (
  // Clock
  input wire mclk_i,
  // Bench request and block answer
  input wire req_i,
  input wire vector_valid_i,
  input wire [15:0] vector_i,
  // Acknowledge and fetched vector
  output logic ack_o = 1'b0,
  output logic [15:0] vec_o = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge mclk_i) begin
    ack_o <= req_i && !ack_o;
    if (vector_valid_i) vec_o <= vector_i;
  end
endmodule

// >>> bench/epv_monitor.sv
// ****************************************
// Core-side vector checks
// ****************************************
module epv_monitor (
  // Clock and reset
  input wire mclk_i,
  input wire reset_n_i,
  // Watched ports
  input wire ack_i,
  input wire por_req_i,
  input wire clkmon_fail_i,
  input wire watchdog_reset_i,
  input wire illegal_op_i,
  input wire soft_interrupt_instr_i,
  input wire ccr_load_i,
  input wire [7:0] ccr_value_i,
  input wire [7:0] ccr_o,
  input wire [15:0] vector_o,
  input wire vector_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire hi = por_req_i | clkmon_fail_i | watchdog_reset_i;
  property p_valid; ack_i |=> vector_valid_o; endproperty
  a_valid: assert property (p_valid) else $error("no valid after ack");
  property p_novalid; !ack_i |=> !vector_valid_o; endproperty
  a_novalid: assert property (p_novalid) else $error("valid without ack");
  property p_top; vector_valid_o |-> vector_o[15:7] == 9'h1ff && !vector_o[0]; endproperty
  a_top: assert property (p_top) else $error("vector outside table");
  property p_por; ack_i && por_req_i |=> vector_o == 16'hfffe; endproperty
  a_por: assert property (p_por) else $error("reset not first");
  property p_trap; ack_i && illegal_op_i && !hi |=> vector_o == 16'hfff8; endproperty
  a_trap: assert property (p_trap) else $error("trap vector wrong");
  property p_swi; ack_i && soft_interrupt_instr_i && !hi && !illegal_op_i |=> vector_o == 16'hfff6; endproperty
  a_swi: assert property (p_swi) else $error("swi vector wrong");
  property p_hold; !ack_i |=> $stable(vector_o); endproperty
  a_hold: assert property (p_hold) else $error("vector moved without ack");
  // Output copy trails the register by one more edge
  property p_ccr; ccr_load_i ##1 1'b1 |=> ccr_o == $past(ccr_value_i, 2); endproperty
  a_ccr: assert property (p_ccr) else $error("ccr load lost");
  // X and I both set: nothing maskable may win
  property p_mask;
    ack_i && ccr_o[4] && ccr_o[6] && !hi && !illegal_op_i && !soft_interrupt_instr_i |=> vector_o == 16'hfff8;
  endproperty
  a_mask: assert property (p_mask) else $error("masked source taken");
  c_por: cover property (ack_i && por_req_i);
  c_open: cover property (ack_i && !ccr_o[4]);
  c_load: cover property (ccr_load_i);
endmodule

bind epv_arbiter epv_monitor i_mon (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ack_i(ack_i),
  .por_req_i(por_req_i), .clkmon_fail_i(clkmon_fail_i), .watchdog_reset_i(watchdog_reset_i),
  .illegal_op_i(illegal_op_i), .soft_interrupt_instr_i(soft_interrupt_instr_i), .ccr_load_i(ccr_load_i),
  .ccr_value_i(ccr_value_i), .ccr_o(ccr_o), .vector_o(vector_o), .vector_valid_o(vector_valid_o));

// >>> bench/exception_priority_vectoring_tb.sv
module exception_priority_vectoring_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, req = 0, ccr_load_i = 0, nmi_n = 1;
  logic [3:0] addr_i = 0;
  logic [7:0] wdata_i = 0, ccr_value_i = 0, tch = 0;
  logic [4:0] nm = 0;
  logic [10:0] mf = 0;
  logic [7:0] lo [11] = '{8'hf2, 8'hf0, 8'hde, 8'hdc, 8'hda, 8'hd8, 8'hd6, 8'hd2, 8'hd0, 8'hcc, 8'hca};
  wire [7:0] rdata_o, ccr_o;
  wire [15:0] vector_o, vec;
  wire vector_valid_o, pending_o, ack;
  int errors = 0, total_checks = 0, cyc = 0;
  epv_arbiter i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_pin_n_i(!mf[0]), .nonmaskable_irq_pin_n_i(nmi_n),
    .por_req_i(nm[4]), .clkmon_fail_i(nm[3]), .watchdog_reset_i(nm[2]), .illegal_op_i(nm[1]),
    .soft_interrupt_instr_i(nm[0]), .rti_flag_i(mf[1]), .timer_ch_flag_i(tch), .timer_ch_enable_i(8'hff),
    .tof_flag_i(mf[2]), .paov_flag_i(mf[3]), .paed_flag_i(mf[4]), .spi_flag_i(mf[5]),
    .sci_req_i({3'h0, mf[6]}), .sci_enable_i(4'hf), .adc_flag_i(mf[7]), .dlc_flag_i(mf[8]),
    .mcz_flag_i(mf[9]), .pbov_flag_i(mf[10]), .ack_i(ack), .ccr_load_i(ccr_load_i),
    .ccr_value_i(ccr_value_i), .vector_o(vector_o), .vector_valid_o(vector_valid_o),
    .pending_o(pending_o), .ccr_o(ccr_o));
  epv_core_model i_core (.mclk_i(mclk_i), .req_i(req), .vector_valid_i(vector_valid_o),
    .vector_i(vector_o), .ack_o(ack), .vec_o(vec));
  initial forever #25 mclk_i = ~mclk_i;
  // ****************************************
  // Shared bus, fetch and compare
  // ****************************************
  task chk(string n, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(logic [3:0] a, logic [7:0] d);
    @(posedge mclk_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge mclk_i) wr_i <= 0;
  endtask
  task rd(logic [3:0] a, logic [7:0] e);
    @(posedge mclk_i) {addr_i, rd_i} <= {a, 1'b1};
    @(posedge mclk_i) rd_i <= 0;
    @(negedge mclk_i) chk("rdata", {8'h00, rdata_o}, {8'h00, e});
  endtask
  // Idle gap first so synchronised pins have settled
  task exc(logic [15:0] e);
    repeat (5) @(posedge mclk_i);
    req <= 1;
    @(posedge mclk_i) req <= 0;
    repeat (3) @(posedge mclk_i);
    #1 chk("vector", vec, e);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task s_reset;
    rd(4'h0, 8'hd0);
    rd(4'h1, 8'hf2);
    rd(4'hf, 8'h00);
    exc(16'hfff8);
    chk("pending", {15'h0000, pending_o}, 16'h0000);
  endtask
  task s_nonmask;
    wr(4'h3, 8'h07);
    for (int i = 0; i < 5; i++) begin
      nm <= 5'h1f >> i;
      exc(16'hfffe - 16'(2 * i));
    end
    nm <= 0;
  endtask
  task s_nmi;
    @(posedge mclk_i) {ccr_load_i, ccr_value_i} <= {1'b1, 8'h90};
    @(posedge mclk_i) {ccr_load_i, nmi_n} <= 2'b00;
    exc(16'hfff4);
    wr(4'h0, 8'hd0);
    exc(16'hfff8);
    nmi_n <= 1;
  endtask
  task s_mask;
    wr(4'h2, 8'hff);
    mf <= 11'h002;
    exc(16'hfff8);
    wr(4'h0, 8'h40);
    for (int k = 0; k < 11; k++) begin
      mf <= 11'h001 << k;
      exc({8'hff, lo[k]});
    end
    mf <= 0;
    for (int n = 0; n < 8; n++) begin
      tch <= 8'h01 << n;
      exc(16'hffee - 16'(2 * n));
    end
    tch <= 0;
  endtask
  // Elevation writes while I is clear must bounce
  task s_prio;
    mf <= 11'h006;
    exc(16'hfff0);
    chk("pending", {15'h0000, pending_o}, 16'h0001);
    wr(4'h1, 8'hde);
    rd(4'h1, 8'hf2);
    wr(4'h0, 8'h50);
    wr(4'h1, 8'hde);
    rd(4'h1, 8'hde);
    wr(4'h0, 8'h40);
    exc(16'hffde);
    wr(4'h2, 8'hfb);
    exc(16'hfff0);
    mf <= 0;
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1;
    s_reset;
    s_nonmask;
    s_nmi;
    s_mask;
    s_prio;
    print_verdict;
  end
endmodule

// >>> common/epv_defines.vh
`ifndef EPV_DEFINES_VH
`define EPV_DEFINES_VH

// ****************************************
// Register map (plain port, byte offsets)
// ****************************************
`define EPV_ADDR_W 4
`define EPV_OFF_CCR 4'h0
`define EPV_OFF_PRIO 4'h1
`define EPV_OFF_EN0 4'h2
`define EPV_OFF_EN1 4'h3
`define EPV_OFF_EN2 4'h4
`define EPV_OFF_STAT 4'h5
`define EPV_OFF_VEC_LO 4'h6
`define EPV_OFF_VEC_HI 4'h7

// ****************************************
// Field positions
// ****************************************
`define EPV_CCR_X 6
`define EPV_CCR_I 4
`define EPV_EN0_IRQ 0
`define EPV_EN0_RTI 1
`define EPV_EN0_TOF 2
`define EPV_EN0_PAOV 3
`define EPV_EN0_PAED 4
`define EPV_EN0_SPI 5
`define EPV_EN0_ADC 6
`define EPV_EN0_DLC 7
`define EPV_EN1_MCZ 0
`define EPV_EN1_PBOV 1
`define EPV_EN1_CME 2
`define EPV_EN1_FORCED_CLOCK_MONITOR_ENABLE 3
`define EPV_EN1_IRQE 4

// ****************************************
// Reset values
// ****************************************
`define EPV_CCR_RST 8'hd0
`define EPV_PRIO_RST 8'hf2
`define EPV_EN_RST 8'h00

// ****************************************
// Vectors
// ****************************************
`define EPV_VEC_RESET 16'hfffe
`define EPV_VEC_CLKMON 16'hfffc
`define EPV_VEC_WDOG 16'hfffa
`define EPV_VEC_TRAP 16'hfff8
`define EPV_VEC_SWI 16'hfff6
`define EPV_VEC_NONMASKABLE_IRQ_PIN 16'hfff4
`define EPV_VEC_BASE 16'hff80
`define EPV_VEC_MASK_TOP 8'hf2
`define EPV_VEC_MASK_BOT 8'hca
`define EPV_NMASK 21

`endif

// >>> verilog/epv_arbiter.v
// Operation
// - Each source owns one fixed 16-bit vector in the top 128 bytes.
// - Six top vectors are resets and non-maskables; the rest maskable.
// - Fixed hardware arbitration picks among simultaneous requests.
// - Non-maskable order: reset, clock monitor, watchdog, trap, swi, nmi pin.
// - Nmi pin accepted only while mask bit X is zero.
// - Maskable requests recognised only while I bit is clear.
// - I bit resets to one and is writable at any time.
// - Default maskable order follows vector address, higher first.
// - Elevation register promotes one source; written value is vector low byte.
// - Elevated source still gated by I bit and local enable.
// - Vector address never depends on priority.
// - Elevation register writes accepted only while I bit is set.
// - Non-maskable vectors FFFE down to FFF4; clock monitor needs enables.
// - Pin FFF2, real-time FFF0, timers FFEE-FFE0, overflow FFDE.
// - Pulse accumulator overflow FFDC, edge FFDA, each locally enabled.
// - Spi FFD8, serial FFD6 on any of four enables, FFD4 reserved, adc FFD2.
// - Down counter FFCC, pulse accumulator B FFCA, data link FFD0.
// - Setting X blocks requests from the nmi pin.
// - Edge mode pin latches edge internally, cleared when serviced.
// - No active source at resolve time gives the trap vector.
`include "epv_defines.vh"

module epv_arbiter (
  // Clock and reset
  input wire mclk_i,
  input wire reset_n_i,
  // Register port
  input wire [`EPV_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Pins, active low
  input wire ext_pin_n_i,
  input wire nonmaskable_irq_pin_n_i,
  // Non-maskable events from the core and monitors (levels)
  input wire por_req_i,
  input wire clkmon_fail_i,
  input wire watchdog_reset_i,
  input wire illegal_op_i,
  input wire soft_interrupt_instr_i,
  // Maskable request flags from peripherals
  input wire rti_flag_i,
  input wire [7:0] timer_ch_flag_i,
  input wire [7:0] timer_ch_enable_i,
  input wire tof_flag_i,
  input wire paov_flag_i,
  input wire paed_flag_i,
  input wire spi_flag_i,
  input wire [3:0] sci_req_i,
  input wire [3:0] sci_enable_i,
  input wire adc_flag_i,
  input wire dlc_flag_i,
  input wire mcz_flag_i,
  input wire pbov_flag_i,
  // Core side
  input wire ack_i,
  input wire ccr_load_i,
  input wire [7:0] ccr_value_i,
  output reg [15:0] vector_o,
  output reg vector_valid_o,
  output reg pending_o,
  output reg [7:0] ccr_o
);
  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] condition_code_reg;
  reg [7:0] priority_elevation_reg;
  reg [7:0] en0;
  reg [7:0] en1;
  reg irq_edge_latch;
  reg pin_prev;
  reg [7:0] next_rdata;

  wire [1:0] pin_lvl;
  wire ext_low;
  wire nmi_low;

  epv_sync #(
    .W(2)
  ) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .async_i({~nonmaskable_irq_pin_n_i, ~ext_pin_n_i}),
    .level_o(pin_lvl)
  );
  assign ext_low = pin_lvl[0];
  assign nmi_low = pin_lvl[1];

  wire i_bit = condition_code_reg[`EPV_CCR_I];
  wire x_bit = condition_code_reg[`EPV_CCR_X];

  // ****************************************
  // Maskable source table, index k has vector FFF2-2k
  // ****************************************
  function [7:0] idx_to_lo;
    input [4:0] k;
    begin
      idx_to_lo = `EPV_VEC_MASK_TOP - {2'b00, k, 1'b0};
    end
  endfunction

  wire ext_req = en0[`EPV_EN0_IRQ] & (en1[`EPV_EN1_IRQE] ? irq_edge_latch : ext_low);
  wire [`EPV_NMASK-1:0] mreq;
  // Slot 15 (FFD4) is reserved and never requests
  assign mreq = {
    pbov_flag_i & en1[`EPV_EN1_PBOV],
    mcz_flag_i & en1[`EPV_EN1_MCZ],
    1'b0,
    dlc_flag_i & en0[`EPV_EN0_DLC],
    adc_flag_i & en0[`EPV_EN0_ADC],
    1'b0,
    |(sci_req_i & sci_enable_i),
    spi_flag_i & en0[`EPV_EN0_SPI],
    paed_flag_i & en0[`EPV_EN0_PAED],
    paov_flag_i & en0[`EPV_EN0_PAOV],
    tof_flag_i & en0[`EPV_EN0_TOF],
    timer_ch_flag_i[7:0] & timer_ch_enable_i[7:0],
    rti_flag_i & en0[`EPV_EN0_RTI],
    ext_req
  };
  // Concatenation already puts channel 0 at index 2 (FFEE) and channel 7 at index 9 (FFE0)
  wire [`EPV_NMASK-1:0] mreq_ord;
  assign mreq_ord = mreq;
  // DLC at FFD0 = slot 17, PBOV FFCA = slot 20, MCZ FFCC = slot 19
  wire [`EPV_NMASK-1:0] mreq_fix = {mreq_ord[20], mreq_ord[19], 1'b0, mreq_ord[17:0]};

  // ****************************************
  // Resolution
  // ****************************************
  reg [15:0] next_vec;
  reg next_any;
  reg found;
  integer k;
  wire [7:0] elev_lo = priority_elevation_reg;
  wire nmi_act = nmi_low & ~x_bit;
  wire clkmon_act = clkmon_fail_i & (en1[`EPV_EN1_CME] | en1[`EPV_EN1_FORCED_CLOCK_MONITOR_ENABLE]);

  always @* begin
    next_vec = `EPV_VEC_TRAP;
    next_any = 1'b1;
    found = 1'b0;
    // Fixed non-maskable ladder
    if (por_req_i) begin
      next_vec = `EPV_VEC_RESET;
    end else if (clkmon_act) begin
      next_vec = `EPV_VEC_CLKMON;
    end else if (watchdog_reset_i) begin
      next_vec = `EPV_VEC_WDOG;
    end else if (illegal_op_i) begin
      next_vec = `EPV_VEC_TRAP;
    end else if (soft_interrupt_instr_i) begin
      next_vec = `EPV_VEC_SWI;
    end else if (nmi_act) begin
      next_vec = `EPV_VEC_NONMASKABLE_IRQ_PIN;
    end else if (!i_bit) begin
      for (k = `EPV_NMASK - 1; k >= 0; k = k - 1) begin
        if (mreq_fix[k]) begin
          next_vec = {8'hff, idx_to_lo(k[4:0])};
          found = 1'b1;
        end
      end
      for (k = 0; k < `EPV_NMASK; k = k + 1) begin
        if (mreq_fix[k] && idx_to_lo(k[4:0]) == elev_lo) begin
          next_vec = {8'hff, elev_lo};
        end
      end
      next_any = found;
    end else begin
      next_any = 1'b0;
    end
  end

  // ****************************************
  // Register port and state
  // ****************************************
  always @* begin
    case (addr_i)
      `EPV_OFF_CCR: next_rdata = condition_code_reg;
      `EPV_OFF_PRIO: next_rdata = priority_elevation_reg;
      `EPV_OFF_EN0: next_rdata = en0;
      `EPV_OFF_EN1: next_rdata = en1;
      `EPV_OFF_STAT: next_rdata = {5'h00, irq_edge_latch, nmi_low, next_any};
      `EPV_OFF_VEC_LO: next_rdata = next_vec[7:0];
      `EPV_OFF_VEC_HI: next_rdata = next_vec[15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  // Edge latch: a new edge beats a service clear in the same cycle
  wire fall_edge = ext_low & ~pin_prev;
  wire ext_served = ack_i & (next_vec == {8'hff, `EPV_VEC_MASK_TOP});

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      condition_code_reg <= `EPV_CCR_RST;
      priority_elevation_reg <= `EPV_PRIO_RST;
      en0 <= `EPV_EN_RST;
      en1 <= `EPV_EN_RST;
      irq_edge_latch <= 1'b0;
      pin_prev <= 1'b0;
      rdata_o <= 8'h00;
      vector_o <= `EPV_VEC_RESET;
      vector_valid_o <= 1'b0;
      pending_o <= 1'b0;
      ccr_o <= `EPV_CCR_RST;
    end else begin
      pin_prev <= ext_low;
      rdata_o <= rd_i ? next_rdata : 8'h00;
      if (ccr_load_i) begin
        condition_code_reg <= ccr_value_i;
      end else if (wr_i && addr_i == `EPV_OFF_CCR) begin
        condition_code_reg <= wdata_i;
      end
      // Only even codes from F2 down to CA are taken, including reserved FFD4 and unused FFCE
      if (wr_i && addr_i == `EPV_OFF_PRIO && i_bit && !wdata_i[0] &&
          wdata_i <= `EPV_VEC_MASK_TOP && wdata_i >= `EPV_VEC_MASK_BOT) begin
        priority_elevation_reg <= wdata_i;
      end
      if (wr_i && addr_i == `EPV_OFF_EN0) begin
        en0 <= wdata_i;
      end
      if (wr_i && addr_i == `EPV_OFF_EN1) begin
        en1 <= wdata_i;
      end
      if (en1[`EPV_EN1_IRQE] && fall_edge) begin
        irq_edge_latch <= 1'b1;
      end else if (ext_served || !en1[`EPV_EN1_IRQE]) begin
        irq_edge_latch <= 1'b0;
      end
      vector_valid_o <= ack_i;
      if (ack_i) begin
        vector_o <= next_vec;
      end
      pending_o <= next_any & (next_vec != `EPV_VEC_TRAP | illegal_op_i);
      ccr_o <= condition_code_reg;
    end
  end
endmodule

// >>> verilog/epv_sync.v
// ****************************************
// Three-stage pin synchroniser
// ****************************************
module epv_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire mclk_i,
  input wire reset_n_i,
  // Pins
  input wire [W-1:0] async_i,
  // Synchronised level, changes once stages two and three agree
  output reg [W-1:0] level_o
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer k;

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      level_o <= {W{1'b0}};
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      for (k = 0; k < W; k = k + 1) begin
        if (s2[k] == s3[k]) begin
          level_o[k] <= s3[k];
        end
      end
    end
  end
endmodule
